// *** testbench/mtac_mac_model.sv ***
// far side: loopback fifo flags and tx statistics pulses
`timescale 1ns/1ns
`default_nettype none
module mtac_mac_model (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [2:0] i_flag_cmd,
  input wire logic [2:0] i_ev_cmd,
  output logic [2:0] o_flags,
  output logic [2:0] o_ev
);
  // launched after the edge; an empty fifo after reset, not a kind one
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_flags <= 3'h4;
      o_ev <= 3'h0;
    end else begin
      o_flags <= i_flag_cmd;
      o_ev <= i_ev_cmd;
    end
  end
endmodule
`default_nettype wire

// *** testbench/mtac_regs_bench.sv ***
// self-checking bench for the test register bank
`timescale 1ns/1ns
`default_nettype none
`define MB_CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
  bad_count++; $display("unexpected %0t got %h exp %h", $time, a, b); end end
module mtac_regs_bench;
  localparam logic [7:0] ID = 8'h96; // arbitrary value
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [15:0] i_addr = 16'h0;
  logic [7:0] i_wdata = 8'h0;
  logic [2:0] flag_cmd = 3'h4;
  logic [2:0] ev_cmd = 3'h0;
  logic [2:0] fl, ev;
  logic [7:0] o_rdata, d, e;
  logic [15:0] o_pause_time, p;
  logic [8:0] o_almost_full_thresh;
  logic o_rd_valid, o_sys_clk_from_rx, o_phy_reset_n, o_loopback_en;
  logic o_addr_swap_en, o_ignore_next_pkt, o_tx_fifo_empty;
  logic o_rx_fifo_full, o_tx_fifo_ctrl, o_send_pause_req;
  logic [7:0] exp_q[$];
  int bad_count = 0;
  int tests_run = 0;
  always #2 i_clock = ~i_clock;
  mtac_mac_model far (.i_clock, .i_rst, .i_flag_cmd(flag_cmd),
    .i_ev_cmd(ev_cmd), .o_flags(fl), .o_ev(ev));
  mtac_regs #(.IDENTITY(ID)) dut (.i_clock, .i_rst, .i_addr, .i_wr, .i_rd,
    .i_wdata, .o_rdata, .o_rd_valid, .i_fifo_empty(fl[2]),
    .i_fifo_full(fl[1]), .i_fifo_almost_full(fl[0]),
    .i_tx_vlan_frame(ev[0]), .i_tx_bad_fcs_frame(ev[1]),
    .i_tx_jumbo_frame(ev[2]), .o_sys_clk_from_rx, .o_phy_reset_n,
    .o_loopback_en, .o_addr_swap_en, .o_ignore_next_pkt, .o_tx_fifo_empty,
    .o_rx_fifo_full, .o_tx_fifo_ctrl, .o_send_pause_req, .o_pause_time,
    .o_almost_full_thresh);
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  // expectation noted when the read is issued
  task automatic rd(input logic [15:0] a, input logic [7:0] x);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    exp_q.push_back(x);
    @(posedge i_clock);
    i_rd <= 1'b0;
  endtask
  always @(negedge i_clock) begin
    if (o_rd_valid === 1'b1) begin
      e = exp_q.size() != 0 ? exp_q.pop_front() : 8'hxx;
      `MB_CHK(o_rdata, e)
    end
  end
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_clock);
    bad_count++;
    give_verdict;
  end
  initial begin
    void'($urandom(32'h7d3ce4f9));
    repeat (10) @(posedge i_clock);
    i_rst <= 1'b0;
    @(negedge i_clock);
    `MB_CHK({o_phy_reset_n, o_pause_time}, 17'h0)
    `MB_CHK(o_almost_full_thresh, 9'h0)
    wr(16'h8002, 8'hff);
    wr(16'h802c, 8'hff);
    for (int a = 0; a < 8; a++) rd(16'h8000 | 16'(a), a ? 8'h0 : ID);
    rd(16'h8032, 8'h0);
    $display("reset values done");
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom());
      p = 16'($urandom());
      wr(16'h8001, d);
      wr(16'h8003, d);
      wr(16'h8004, p[7:0]);
      wr(16'h8005, p[15:8]);
      wr(16'h8006, p[7:0]);
      wr(16'h8007, p[15:8]);
      @(negedge i_clock);
      `MB_CHK({o_sys_clk_from_rx, o_phy_reset_n}, d[3:2])
      `MB_CHK({o_loopback_en, o_addr_swap_en}, d[1:0])
      `MB_CHK({o_ignore_next_pkt, o_tx_fifo_ctrl}, {d[4], d[1]})
      `MB_CHK({o_pause_time, o_almost_full_thresh}, {p, p[8:0]})
      rd(16'h8001, d & 8'h0f);
      rd(16'h8003, d & 8'h1f);
      rd(16'h8007, {7'h0, p[8]});
    end
    $display("control registers done");
    for (int i = 0; i < 4; i++) begin
      wr(16'h8003, i[1] ? 8'h0d : 8'h00);
      flag_cmd <= {3{i[0]}};
      repeat (2) @(negedge i_clock);
      d = {7'h0, i[0] | i[1]};
      `MB_CHK(o_tx_fifo_empty, d[0])
      `MB_CHK(o_rx_fifo_full, d[0])
      `MB_CHK(o_send_pause_req, d[0])
    end
    $display("sideband or done");
    for (int c = 0; c < 300; c++) begin
      @(posedge i_clock);
      ev_cmd <= {c < 258, c < 5, 1'b1};
    end
    @(posedge i_clock);
    ev_cmd <= 3'h0;
    for (int k = 0; k < 3; k++) begin
      p = k == 0 ? 16'd300 : k == 1 ? 16'd5 : 16'd258;
      rd(16'h802d + 16'(2 * k), p[15:8]);
      rd(16'h802c + 16'(2 * k), p[7:0]);
      rd(16'h802d + 16'(2 * k), 8'h0);
    end
    @(posedge i_clock);
    ev_cmd <= 3'h1;
    @(posedge i_clock);
    ev_cmd <= 3'h0;
    i_rd <= 1'b1;
    i_addr <= 16'h802c;
    exp_q.push_back(8'h0);
    @(posedge i_clock);
    i_rd <= 1'b0;
    rd(16'h802c, 8'h1);
    for (int k = 0; k < 8 && exp_q.size() != 0; k++) @(negedge i_clock);
    `MB_CHK(exp_q.size(), 0)
    $display("counters done");
    @(posedge i_clock);
    i_rst <= 1'b1;
    @(posedge i_clock);
    i_rst <= 1'b0;
    @(negedge i_clock);
    `MB_CHK({o_phy_reset_n, o_pause_time, o_rd_valid}, 18'h0)
    rd(16'h8001, 8'h0);
    repeat (2) @(negedge i_clock);
    `MB_CHK(exp_q.size(), 0)
    $display("second reset done");
    give_verdict;
  end
endmodule
`default_nettype wire

// *** testbench/mtac_regs_checker.sv ***
// assertions on the test register bank ports
`timescale 1ns/1ns
`default_nettype none
module mtac_regs_checker #(
  parameter logic [7:0] IDENTITY = 8'h5c
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [15:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic o_rd_valid,
  input wire logic i_fifo_empty,
  input wire logic i_fifo_full,
  input wire logic i_fifo_almost_full,
  input wire logic o_phy_reset_n,
  input wire logic o_tx_fifo_empty,
  input wire logic o_rx_fifo_full,
  input wire logic o_send_pause_req,
  input wire logic [15:0] o_pause_time
);
  logic [7:0] wd_q;
  always_ff @(posedge i_clock) wd_q <= i_wdata;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  sequence s_wr_test;
    i_wr && i_addr == 16'h8001;
  endsequence
  sequence s_rd_ident;
    i_rd && i_addr == 16'h8000;
  endsequence
  a_rd_valid_lag: assert property (i_rd |=> o_rd_valid)
    else $error("read answer missing");
  a_rd_valid_only: assert property (!i_rd |=> !o_rd_valid)
    else $error("read answer unasked");
  a_ident_read: assert property (s_rd_ident |=> o_rdata == IDENTITY)
    else $error("identity wrong");
  a_phy_write: assert property (s_wr_test |=> o_phy_reset_n == wd_q[2])
    else $error("phy reset wrong");
  a_empty_or: assert property (i_fifo_empty |-> o_tx_fifo_empty)
    else $error("empty not passed");
  a_full_or: assert property (i_fifo_full |-> o_rx_fifo_full)
    else $error("full not passed");
  a_pause_or: assert property (
    i_fifo_almost_full |-> o_send_pause_req)
    else $error("pause not passed");
  a_pause_low: assert property (i_wr && i_addr == 16'h8004 |=>
    o_pause_time[7:0] == wd_q) else $error("pause low wrong");
endmodule
bind mtac_regs mtac_regs_checker #(.IDENTITY(IDENTITY)) u_chk (.i_clock,
  .i_rst, .i_addr, .i_wr, .i_rd, .i_wdata, .o_rdata, .o_rd_valid,
  .i_fifo_empty, .i_fifo_full, .i_fifo_almost_full, .o_phy_reset_n,
  .o_tx_fifo_empty, .o_rx_fifo_full, .o_send_pause_req, .o_pause_time);
`default_nettype wire

// *** verilog/mtac_cfg.svh ***
// offsets, field positions and reset values of the test register bank
`ifndef MTAC_CFG_SVH
`define MTAC_CFG_SVH

`define MTAC_ADDR_W 16
`define MTAC_DATA_W 8
`define MTAC_CNT_W 16

`define MTAC_OFS_IDENTITY 16'h8000
`define MTAC_OFS_TEST_CTRL 16'h8001
`define MTAC_OFS_TEST_CTRL2 16'h8002
`define MTAC_OFS_MAC_CTRL 16'h8003
`define MTAC_OFS_PAUSE_LO 16'h8004
`define MTAC_OFS_PAUSE_HI 16'h8005
`define MTAC_OFS_AFULL_LO 16'h8006
`define MTAC_OFS_AFULL_HI 16'h8007
`define MTAC_OFS_VLAN_LO 16'h802c
`define MTAC_OFS_VLAN_HI 16'h802d
`define MTAC_OFS_BADFCS_LO 16'h802e
`define MTAC_OFS_BADFCS_HI 16'h802f
`define MTAC_OFS_JUMBO_LO 16'h8030
`define MTAC_OFS_JUMBO_HI 16'h8031

`define MTAC_TC_CLKSEL 3
`define MTAC_TC_PHY_RST_N 2
`define MTAC_TC_LOOP_EN 1
`define MTAC_TC_ADDR_SWAP 0
`define MTAC_TC_MASK 8'h0f

`define MTAC_MC_IGNORE_NEXT 4
`define MTAC_MC_FORCE_EMPTY 3
`define MTAC_MC_FORCE_FULL 2
`define MTAC_MC_CTRL_FRAME 1
`define MTAC_MC_PAUSE_REQ 0
`define MTAC_MC_MASK 8'h1f

`define MTAC_AFH_MASK 8'h01
`define MTAC_RST_BYTE 8'h00

`endif

// *** verilog/mtac_pkg.sv ***
// types shared by the test register bank
package mtac_pkg;

  typedef logic [7:0] mtac_byte_t;

  typedef enum {
    MTAC_SEL_NONE,
    MTAC_SEL_IDENTITY,
    MTAC_SEL_TEST_CTRL,
    MTAC_SEL_TEST_CTRL2,
    MTAC_SEL_MAC_CTRL,
    MTAC_SEL_PAUSE_LO,
    MTAC_SEL_PAUSE_HI,
    MTAC_SEL_AFULL_LO,
    MTAC_SEL_AFULL_HI,
    MTAC_SEL_VLAN_LO,
    MTAC_SEL_VLAN_HI,
    MTAC_SEL_BADFCS_LO,
    MTAC_SEL_BADFCS_HI,
    MTAC_SEL_JUMBO_LO,
    MTAC_SEL_JUMBO_HI
  } mtac_sel_t;

endpackage

// *** verilog/mtac_regs.sv ***
// control, status and statistics register bank of the test application
`timescale 1ns/1ns
`default_nettype none
`include "mtac_cfg.svh"
module mtac_regs #(
  // value is arbitrary
  parameter logic [7:0] IDENTITY = 8'h5c,
  parameter int CNT_W = `MTAC_CNT_W
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [`MTAC_ADDR_W-1:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [`MTAC_DATA_W-1:0] i_wdata,
  output logic [`MTAC_DATA_W-1:0] o_rdata,
  output logic o_rd_valid,
  input wire logic i_fifo_empty,
  input wire logic i_fifo_full,
  input wire logic i_fifo_almost_full,
  input wire logic i_tx_vlan_frame,
  input wire logic i_tx_bad_fcs_frame,
  input wire logic i_tx_jumbo_frame,
  output logic o_sys_clk_from_rx,
  output logic o_phy_reset_n,
  output logic o_loopback_en,
  output logic o_addr_swap_en,
  output logic o_ignore_next_pkt,
  output logic o_tx_fifo_empty,
  output logic o_rx_fifo_full,
  output logic o_tx_fifo_ctrl,
  output logic o_send_pause_req,
  output logic [15:0] o_pause_time,
  output logic [8:0] o_almost_full_thresh
);

  mtac_pkg::mtac_sel_t sel;
  mtac_pkg::mtac_byte_t test_ctrl_reg;
  mtac_pkg::mtac_byte_t mac_ctrl_reg;
  mtac_pkg::mtac_byte_t pause_lo_reg;
  mtac_pkg::mtac_byte_t pause_hi_reg;
  mtac_pkg::mtac_byte_t afull_lo_reg;
  mtac_pkg::mtac_byte_t afull_hi_reg;
  mtac_pkg::mtac_byte_t rdata_next;
  mtac_pkg::mtac_byte_t rdata_reg;
  logic rd_valid_reg;
  logic wr_test_ctrl;
  logic wr_mac_ctrl;
  logic wr_pause_lo;
  logic wr_pause_hi;
  logic wr_afull_lo;
  logic wr_afull_hi;
  logic clr_vlan;
  logic clr_badfcs;
  logic clr_jumbo;
  logic [CNT_W-1:0] vlan_count;
  logic [CNT_W-1:0] badfcs_count;
  logic [CNT_W-1:0] jumbo_count;
  mtac_pkg::mtac_byte_t test_ctrl_next;
  mtac_pkg::mtac_byte_t mac_ctrl_next;
  mtac_pkg::mtac_byte_t pause_lo_next;
  mtac_pkg::mtac_byte_t pause_hi_next;
  mtac_pkg::mtac_byte_t afull_lo_next;
  mtac_pkg::mtac_byte_t afull_hi_next;
  mtac_pkg::mtac_byte_t vlan_lo;
  mtac_pkg::mtac_byte_t vlan_hi;
  mtac_pkg::mtac_byte_t badfcs_lo;
  mtac_pkg::mtac_byte_t badfcs_hi;
  mtac_pkg::mtac_byte_t jumbo_lo;
  mtac_pkg::mtac_byte_t jumbo_hi;

  // address decode; everything off the map selects nothing
  always_comb begin
    case (i_addr)
      `MTAC_OFS_IDENTITY: begin
        sel = mtac_pkg::MTAC_SEL_IDENTITY;
      end
      `MTAC_OFS_TEST_CTRL: begin
        sel = mtac_pkg::MTAC_SEL_TEST_CTRL;
      end
      `MTAC_OFS_TEST_CTRL2: begin
        sel = mtac_pkg::MTAC_SEL_TEST_CTRL2;
      end
      `MTAC_OFS_MAC_CTRL: begin
        sel = mtac_pkg::MTAC_SEL_MAC_CTRL;
      end
      `MTAC_OFS_PAUSE_LO: begin
        sel = mtac_pkg::MTAC_SEL_PAUSE_LO;
      end
      `MTAC_OFS_PAUSE_HI: begin
        sel = mtac_pkg::MTAC_SEL_PAUSE_HI;
      end
      `MTAC_OFS_AFULL_LO: begin
        sel = mtac_pkg::MTAC_SEL_AFULL_LO;
      end
      `MTAC_OFS_AFULL_HI: begin
        sel = mtac_pkg::MTAC_SEL_AFULL_HI;
      end
      `MTAC_OFS_VLAN_LO: begin
        sel = mtac_pkg::MTAC_SEL_VLAN_LO;
      end
      `MTAC_OFS_VLAN_HI: begin
        sel = mtac_pkg::MTAC_SEL_VLAN_HI;
      end
      `MTAC_OFS_BADFCS_LO: begin
        sel = mtac_pkg::MTAC_SEL_BADFCS_LO;
      end
      `MTAC_OFS_BADFCS_HI: begin
        sel = mtac_pkg::MTAC_SEL_BADFCS_HI;
      end
      `MTAC_OFS_JUMBO_LO: begin
        sel = mtac_pkg::MTAC_SEL_JUMBO_LO;
      end
      `MTAC_OFS_JUMBO_HI: begin
        sel = mtac_pkg::MTAC_SEL_JUMBO_HI;
      end
      default: begin
        sel = mtac_pkg::MTAC_SEL_NONE;
      end
    endcase
  end

  // write strobes; read-only and reserved locations have none
  assign wr_test_ctrl = i_wr && (sel == mtac_pkg::MTAC_SEL_TEST_CTRL);
  assign wr_mac_ctrl = i_wr && (sel == mtac_pkg::MTAC_SEL_MAC_CTRL);
  assign wr_pause_lo = i_wr && (sel == mtac_pkg::MTAC_SEL_PAUSE_LO);
  assign wr_pause_hi = i_wr && (sel == mtac_pkg::MTAC_SEL_PAUSE_HI);
  assign wr_afull_lo = i_wr && (sel == mtac_pkg::MTAC_SEL_AFULL_LO);
  assign wr_afull_hi = i_wr && (sel == mtac_pkg::MTAC_SEL_AFULL_HI);

  // only the low byte read clears; high byte is read first
  assign clr_vlan = i_rd && (sel == mtac_pkg::MTAC_SEL_VLAN_LO);
  assign clr_badfcs = i_rd && (sel == mtac_pkg::MTAC_SEL_BADFCS_LO);
  assign clr_jumbo = i_rd && (sel == mtac_pkg::MTAC_SEL_JUMBO_LO);

  // masked next values; reserved bits never reach a flop
  assign test_ctrl_next = i_wdata & `MTAC_TC_MASK;
  assign mac_ctrl_next = i_wdata & `MTAC_MC_MASK;
  assign pause_lo_next = i_wdata;
  assign pause_hi_next = i_wdata;
  assign afull_lo_next = i_wdata;
  assign afull_hi_next = i_wdata & `MTAC_AFH_MASK;

  // reserved bits never stored, so they read back as zero
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      test_ctrl_reg <= `MTAC_RST_BYTE;
    end else if (wr_test_ctrl) begin
      test_ctrl_reg <= test_ctrl_next;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      mac_ctrl_reg <= `MTAC_RST_BYTE;
    end else if (wr_mac_ctrl) begin
      mac_ctrl_reg <= mac_ctrl_next;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      pause_lo_reg <= `MTAC_RST_BYTE;
    end else if (wr_pause_lo) begin
      pause_lo_reg <= pause_lo_next;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      pause_hi_reg <= `MTAC_RST_BYTE;
    end else if (wr_pause_hi) begin
      pause_hi_reg <= pause_hi_next;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      afull_lo_reg <= `MTAC_RST_BYTE;
    end else if (wr_afull_lo) begin
      afull_lo_reg <= afull_lo_next;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      afull_hi_reg <= `MTAC_RST_BYTE;
    end else if (wr_afull_hi) begin
      afull_hi_reg <= afull_hi_next;
    end
  end

  // transmit statistics counters
  mtac_stat_counter #(
    .WIDTH(CNT_W)
  ) u_vlan_count (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_event(i_tx_vlan_frame),
    .i_clear(clr_vlan),
    .o_count(vlan_count)
  );

  mtac_stat_counter #(
    .WIDTH(CNT_W)
  ) u_badfcs_count (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_event(i_tx_bad_fcs_frame),
    .i_clear(clr_badfcs),
    .o_count(badfcs_count)
  );

  mtac_stat_counter #(
    .WIDTH(CNT_W)
  ) u_jumbo_count (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_event(i_tx_jumbo_frame),
    .i_clear(clr_jumbo),
    .o_count(jumbo_count)
  );

  // byte views; the host sees each counter as two bytes
  assign vlan_lo = vlan_count[7:0];
  assign vlan_hi = vlan_count[15:8];
  assign badfcs_lo = badfcs_count[7:0];
  assign badfcs_hi = badfcs_count[15:8];
  assign jumbo_lo = jumbo_count[7:0];
  assign jumbo_hi = jumbo_count[15:8];

  // read mux samples the counter before its clear lands
  always_comb begin
    case (sel)
      mtac_pkg::MTAC_SEL_IDENTITY: begin
        rdata_next = IDENTITY;
      end
      mtac_pkg::MTAC_SEL_TEST_CTRL: begin
        rdata_next = test_ctrl_reg;
      end
      mtac_pkg::MTAC_SEL_TEST_CTRL2: begin
        rdata_next = `MTAC_RST_BYTE;
      end
      mtac_pkg::MTAC_SEL_MAC_CTRL: begin
        rdata_next = mac_ctrl_reg;
      end
      mtac_pkg::MTAC_SEL_PAUSE_LO: begin
        rdata_next = pause_lo_reg;
      end
      mtac_pkg::MTAC_SEL_PAUSE_HI: begin
        rdata_next = pause_hi_reg;
      end
      mtac_pkg::MTAC_SEL_AFULL_LO: begin
        rdata_next = afull_lo_reg;
      end
      mtac_pkg::MTAC_SEL_AFULL_HI: begin
        rdata_next = afull_hi_reg;
      end
      mtac_pkg::MTAC_SEL_VLAN_LO: begin
        rdata_next = vlan_lo;
      end
      mtac_pkg::MTAC_SEL_VLAN_HI: begin
        rdata_next = vlan_hi;
      end
      mtac_pkg::MTAC_SEL_BADFCS_LO: begin
        rdata_next = badfcs_lo;
      end
      mtac_pkg::MTAC_SEL_BADFCS_HI: begin
        rdata_next = badfcs_hi;
      end
      mtac_pkg::MTAC_SEL_JUMBO_LO: begin
        rdata_next = jumbo_lo;
      end
      mtac_pkg::MTAC_SEL_JUMBO_HI: begin
        rdata_next = jumbo_hi;
      end
      default: begin
        rdata_next = `MTAC_RST_BYTE;
      end
    endcase
  end

  // read data held until the next read
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rdata_reg <= `MTAC_RST_BYTE;
    end else if (i_rd) begin
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= i_rd;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_rd_valid = rd_valid_reg;

  // board and loopback controls straight from the register
  assign o_sys_clk_from_rx = test_ctrl_reg[`MTAC_TC_CLKSEL];
  assign o_phy_reset_n = test_ctrl_reg[`MTAC_TC_PHY_RST_N];
  assign o_loopback_en = test_ctrl_reg[`MTAC_TC_LOOP_EN];
  assign o_addr_swap_en = test_ctrl_reg[`MTAC_TC_ADDR_SWAP];

  // mac sideband; fifo flags are same-clock logic, no resync
  assign o_ignore_next_pkt = mac_ctrl_reg[`MTAC_MC_IGNORE_NEXT];
  // one fifo, so its flags feed both tx and rx status pins
  assign o_tx_fifo_empty = mac_ctrl_reg[`MTAC_MC_FORCE_EMPTY]
                           | i_fifo_empty;
  assign o_rx_fifo_full = mac_ctrl_reg[`MTAC_MC_FORCE_FULL]
                          | i_fifo_full;
  assign o_tx_fifo_ctrl = mac_ctrl_reg[`MTAC_MC_CTRL_FRAME];
  assign o_send_pause_req = mac_ctrl_reg[`MTAC_MC_PAUSE_REQ]
                            | i_fifo_almost_full;

  assign o_pause_time = {pause_hi_reg, pause_lo_reg};
  assign o_almost_full_thresh = {afull_hi_reg[0], afull_lo_reg};

endmodule
`default_nettype wire

// *** verilog/mtac_stat_counter.sv ***
// 16-bit statistics counter, cleared by a read strobe
`timescale 1ns/1ns
`default_nettype none
module mtac_stat_counter #(
  parameter int WIDTH = 16
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_event,
  input wire logic i_clear,
  output logic [WIDTH-1:0] o_count
);

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;

  // a count in the clearing cycle survives as one
  always_comb begin
    if (i_clear) begin
      count_next = {{(WIDTH-1){1'b0}}, i_event};
    end else if (i_event) begin
      count_next = count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
    end else begin
      count_next = count_reg;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign o_count = count_reg;

endmodule
`default_nettype wire
